// file: common/ccw_pkg.sv
/*
 * Constants, register map and mode encodings for the CPU clock mode and
 * wait control block. Assumes a 32-bit APB slave with word registers.
 */
package ccw_pkg;
    // ----------------------------------------
    // register byte addresses
    // ----------------------------------------
    localparam logic [7:0] CCW_ADDR_CC0 = 8'h00;
    localparam logic [7:0] CCW_ADDR_CC1 = 8'h04;
    localparam logic [7:0] CCW_ADDR_OSD = 8'h08;
    localparam logic [7:0] CCW_ADDR_PLL = 8'h0c;
    localparam logic [7:0] CCW_ADDR_PMT = 8'h10;
    localparam logic [7:0] CCW_ADDR_STAT = 8'h14;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CCW_CC0_CKO_LSB = 0;
    localparam int CCW_CC0_GATE = 2;
    localparam int CCW_CC0_SUB_EN = 4;
    localparam int CCW_CC0_MAIN_STOP = 5;
    localparam int CCW_CC0_DIV8 = 6;
    localparam int CCW_CC0_SUB_CPU = 7;
    localparam int CCW_CC1_PLL_SEL = 1;
    localparam int CCW_CC1_DIV_LSB = 6;
    localparam int CCW_OSD_IOC = 1;
    localparam int CCW_PLL_RUN = 7;
    localparam int CCW_PMT_WDT = 2;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] CCW_CC0_RST = 8'h40;
    localparam logic [7:0] CCW_CC1_RST = 8'h00;
    localparam logic [7:0] CCW_OSD_RST = 8'h00;
    localparam logic [7:0] CCW_PLL_RST = 8'h00;
    localparam logic [7:0] CCW_PMT_RST = 8'h00;
    // ----------------------------------------
    // encodings
    // ----------------------------------------
    localparam logic [1:0] CCW_CKO_PORT = 2'h0;
    localparam logic [1:0] CCW_CKO_SUB = 2'h1;
    localparam logic [1:0] CCW_CKO_F8 = 2'h2;
    localparam logic [1:0] CCW_CKO_F32 = 2'h3;
    localparam int CCW_SRC_MAIN = 0;
    localparam int CCW_SRC_SUB = 1;
    localparam int CCW_SRC_IOC = 2;
    localparam int CCW_SRC_PLL = 3;
    localparam int CCW_NSRC = 4;

    typedef enum logic [2:0] {
        CCW_M_PLL = 3'b000,
        CCW_M_HIGH = 3'b001,
        CCW_M_MEDIUM = 3'b010,
        CCW_M_LOW_SPEED = 3'b011,
        CCW_M_LOW_POWER = 3'b100,
        CCW_M_IOC = 3'b101,
        CCW_M_IOC_LOW_POWER = 3'b110
    } ccw_mode_t;

    typedef enum logic [0:0] {
        CCW_S_RUN = 1'b0,
        CCW_S_WAIT = 1'b1
    } ccw_state_t;
endpackage

// file: src/ccw_top.sv
/*
 * CPU clock mode and wait control: source and divider selection for the
 * CPU and peripheral clock enables, wait mode gating and pin holding.
 * Assumes oscillator ticks arrive as asynchronous level toggles on pins,
 * and that the CPU and bus controller run on ref_clk.
 */
// Behaviour
// - low power mode: main oscillator off, CPU on sub clock, divided sub clock for timers
// - main stop written in low speed mode forces divide-by-eight to one
// - internal oscillator mode: CPU from oscillator divided, peripherals from it
// - oscillator low power mode: main stopped, oscillator feeds peripherals
// - oscillator low power mode uses the same CPU divider choice
// - sub clock running offers divided sub clock to timers in both oscillator modes
// - divider field 00/01/10/11 is 1/2/4/16; eight bit forces 8
// - wait mode gates CPU clock and halts the watchdog
// - watchdog on internal oscillator keeps counting during wait
// - oscillators keep running during wait mode
// - gate bit stops divided peripheral and converter clocks in wait, not sub divide
// - wait entered only when the CPU executes the wait instruction
// - bus address, data, selects and byte enable hold pre-wait values in external bus mode
// - in external bus mode wait strobes, hold acknowledge, bus clock high; address latch low
// - clock output: sub clock keeps toggling; divided clocks freeze when gated
module ccw_top
    import ccw_pkg::*;
#(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 16,
    parameter int CS_W = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic main_osc_pin,
    input wire logic sub_osc_pin,
    input wire logic ioc_osc_pin,
    input wire logic pll_osc_pin,
    input wire logic wait_exec,
    input wire logic wait_wake,
    input wire logic ext_bus_mode,
    input wire logic [ADDR_W-1:0] bus_addr_in,
    input wire logic [DATA_W-1:0] bus_data_in,
    input wire logic [CS_W-1:0] chip_select_n_in,
    input wire logic byte_high_enable_in,
    input wire logic read_n_in,
    input wire logic write_n_in,
    input wire logic write_low_strobe_n_in,
    input wire logic write_high_strobe_n_in,
    input wire logic hold_acknowledge_n_in,
    input wire logic addr_latch_in,
    output logic [ADDR_W-1:0] bus_addr,
    output logic [DATA_W-1:0] bus_data,
    output logic [CS_W-1:0] chip_select_n,
    output logic byte_high_enable,
    output logic read_n,
    output logic write_n,
    output logic write_low_strobe_n,
    output logic write_high_strobe_n,
    output logic hold_acknowledge_n,
    output logic addr_latch,
    output logic bus_clock,
    output logic clock_output_pin,
    output logic clock_output_oe,
    output logic cpu_clk_en,
    output logic watchdog_tick,
    output logic f1_tick,
    output logic f2_tick,
    output logic f8_tick,
    output logic f32_tick,
    output logic converter_clock_tick,
    output logic sub_clock_div32_tick,
    output logic main_osc_run,
    output logic sub_osc_run,
    output logic pll_enable,
    output logic in_wait
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] cc0_q;
    logic [7:0] cc1_q;
    logic [7:0] osd_q;
    logic [7:0] pll_q;
    logic [7:0] pmt_q;
    ccw_state_t state_q;
    ccw_mode_t mode;

    logic divide_by_eight_select;
    logic main_osc_stop;
    logic sub_osc_enable;
    logic sub_clock_cpu_select;
    logic periph_clock_gate_in_wait;
    logic [1:0] cosel;
    logic pll_cpu_source_select;
    logic [1:0] cpu_divider_field;
    logic internal_osc_select;
    logic pll_run;
    logic watchdog_source_select;

    assign divide_by_eight_select = cc0_q[CCW_CC0_DIV8];
    assign main_osc_stop = cc0_q[CCW_CC0_MAIN_STOP];
    assign sub_osc_enable = cc0_q[CCW_CC0_SUB_EN];
    assign sub_clock_cpu_select = cc0_q[CCW_CC0_SUB_CPU];
    assign periph_clock_gate_in_wait = cc0_q[CCW_CC0_GATE];
    assign cosel = cc0_q[CCW_CC0_CKO_LSB+:2];
    assign pll_cpu_source_select = cc1_q[CCW_CC1_PLL_SEL];
    assign cpu_divider_field = cc1_q[CCW_CC1_DIV_LSB+:2];
    assign internal_osc_select = osd_q[CCW_OSD_IOC];
    assign pll_run = pll_q[CCW_PLL_RUN];
    assign watchdog_source_select = pmt_q[CCW_PMT_WDT];

    function automatic logic [4:0] div_ratio(input logic eight, input logic [1:0] fld);
        logic [4:0] r;
        r = 5'h01;
        if (eight) begin
            r = 5'h08;
        end else if (fld == 2'h1) begin
            r = 5'h02;
        end else if (fld == 2'h2) begin
            r = 5'h04;
        end else if (fld == 2'h3) begin
            r = 5'h10;
        end
        return r;
    endfunction

    // ----------------------------------------
    // mode derivation
    // ----------------------------------------
    always_comb begin
        if (internal_osc_select && !sub_clock_cpu_select) begin
            mode = main_osc_stop ? CCW_M_IOC_LOW_POWER : CCW_M_IOC;
        end else if (sub_clock_cpu_select) begin
            mode = main_osc_stop ? CCW_M_LOW_POWER : CCW_M_LOW_SPEED;
        end else if (pll_cpu_source_select) begin
            mode = CCW_M_PLL;
        end else if (divide_by_eight_select || cpu_divider_field != 2'h0) begin
            mode = CCW_M_MEDIUM;
        end else begin
            mode = CCW_M_HIGH;
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    logic setup;
    logic access;
    logic wr_cc0;
    assign setup = psel && !penable;
    assign access = psel && penable && pready;
    assign wr_cc0 = access && pwrite && paddr == CCW_ADDR_CC0;

    // no wait states: pready answers in the cycle after setup
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= 1'b0;
            if (paddr == CCW_ADDR_CC0) begin
                prdata <= {24'h000000, cc0_q};
            end else if (paddr == CCW_ADDR_CC1) begin
                prdata <= {24'h000000, cc1_q};
            end else if (paddr == CCW_ADDR_OSD) begin
                prdata <= {24'h000000, osd_q};
            end else if (paddr == CCW_ADDR_PLL) begin
                prdata <= {24'h000000, pll_q};
            end else if (paddr == CCW_ADDR_PMT) begin
                prdata <= {24'h000000, pmt_q};
            end else if (paddr == CCW_ADDR_STAT) begin
                prdata <= {28'h0000000, state_q, mode};
            end else begin
                prdata <= 32'h0000_0000;
                pslverr <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cc0_q <= CCW_CC0_RST;
        end else if (wr_cc0) begin
            cc0_q <= pwdata[7:0];
            // stop main in low speed forces divide by eight
            if (pwdata[CCW_CC0_MAIN_STOP] && mode == CCW_M_LOW_SPEED) begin
                cc0_q[CCW_CC0_DIV8] <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cc1_q <= CCW_CC1_RST;
            osd_q <= CCW_OSD_RST;
            pll_q <= CCW_PLL_RST;
            pmt_q <= CCW_PMT_RST;
        end else if (access && pwrite) begin
            if (paddr == CCW_ADDR_CC1) begin
                cc1_q <= pwdata[7:0];
            end else if (paddr == CCW_ADDR_OSD) begin
                osd_q <= pwdata[7:0];
            end else if (paddr == CCW_ADDR_PLL) begin
                pll_q <= pwdata[7:0];
            end else if (paddr == CCW_ADDR_PMT) begin
                pmt_q <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // wait state
    // ----------------------------------------
    // wait only on instruction
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= CCW_S_RUN;
        end else if (state_q == CCW_S_RUN && wait_exec) begin
            state_q <= CCW_S_WAIT;
        end else if (state_q == CCW_S_WAIT && wait_wake) begin
            state_q <= CCW_S_RUN;
        end
    end

    logic waiting;
    assign waiting = state_q == CCW_S_WAIT;

    // ----------------------------------------
    // oscillator tick synchronisers
    // ----------------------------------------
    logic [CCW_NSRC-1:0] osc_pin;
    logic [CCW_NSRC-1:0] tick;
    assign osc_pin = {pll_osc_pin, ioc_osc_pin, sub_osc_pin, main_osc_pin};

    genvar g;
    generate
        for (g = 0; g < CCW_NSRC; g++) begin : g_sync
            logic s1_q;
            logic s2_q;
            logic s3_q;
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                end else begin
                    s1_q <= osc_pin[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end
            // one tick per rising edge of the oscillator
            assign tick[g] = s2_q && !s3_q;
        end
    endgenerate

    logic main_on;
    logic sub_on;
    logic pll_on;
    assign main_on = !main_osc_stop;
    assign sub_on = sub_osc_enable;
    assign pll_on = pll_run;

    // ----------------------------------------
    // CPU clock divider
    // ----------------------------------------
    logic cpu_src_tick;
    logic [4:0] ratio;
    logic [4:0] cnt_q;
    logic cpu_pulse;

    always_comb begin
        if (sub_clock_cpu_select) begin
            cpu_src_tick = tick[CCW_SRC_SUB] && sub_on;
        end else if (internal_osc_select) begin
            cpu_src_tick = tick[CCW_SRC_IOC];
        end else if (pll_cpu_source_select) begin
            cpu_src_tick = tick[CCW_SRC_PLL] && pll_on;
        end else begin
            cpu_src_tick = tick[CCW_SRC_MAIN] && main_on;
        end
    end

    // sub clock and PLL run undivided
    assign ratio = (sub_clock_cpu_select || (pll_cpu_source_select && !internal_osc_select))
        ? 5'h01 : div_ratio(divide_by_eight_select, cpu_divider_field);
    assign cpu_pulse = cpu_src_tick && (cnt_q + 5'h01 >= ratio);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_q <= 5'h00;
        end else if (cpu_src_tick) begin
            cnt_q <= cpu_pulse ? 5'h00 : cnt_q + 5'h01;
        end
    end

    // CPU halted in wait; watchdog too unless it runs from the internal oscillator
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cpu_clk_en <= 1'b0;
            watchdog_tick <= 1'b0;
        end else begin
            cpu_clk_en <= cpu_pulse && !waiting;
            if (watchdog_source_select) begin
                watchdog_tick <= tick[CCW_SRC_IOC];
            end else begin
                watchdog_tick <= cpu_pulse && !waiting;
            end
        end
    end

    // ----------------------------------------
    // peripheral clocks
    // ----------------------------------------
    logic per_src_tick;
    logic per_run;
    logic [4:0] pcnt_q;
    logic [4:0] scnt_q;
    logic sdiv_pulse;

    always_comb begin
        if (internal_osc_select) begin
            per_src_tick = tick[CCW_SRC_IOC];
        end else if (pll_cpu_source_select) begin
            per_src_tick = tick[CCW_SRC_PLL] && pll_on;
        end else begin
            per_src_tick = tick[CCW_SRC_MAIN] && main_on;
        end
    end

    // divided clocks off in gated wait
    assign per_run = per_src_tick && mode != CCW_M_LOW_POWER
        && !(waiting && periph_clock_gate_in_wait);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pcnt_q <= 5'h00;
        end else if (per_run) begin
            pcnt_q <= pcnt_q + 5'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            f1_tick <= 1'b0;
            f2_tick <= 1'b0;
            f8_tick <= 1'b0;
            f32_tick <= 1'b0;
            converter_clock_tick <= 1'b0;
        end else begin
            f1_tick <= per_run;
            f2_tick <= per_run && pcnt_q[0];
            f8_tick <= per_run && pcnt_q[2:0] == 3'h7;
            f32_tick <= per_run && pcnt_q == 5'h1f;
            converter_clock_tick <= per_run;
        end
    end

    assign sdiv_pulse = tick[CCW_SRC_SUB] && sub_on && scnt_q == 5'h1f;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            scnt_q <= 5'h00;
            sub_clock_div32_tick <= 1'b0;
        end else begin
            if (tick[CCW_SRC_SUB] && sub_on) begin
                scnt_q <= scnt_q + 5'h01;
            end
            sub_clock_div32_tick <= sdiv_pulse;
        end
    end

    // ----------------------------------------
    // clock output pin
    // ----------------------------------------
    logic co_tick;
    always_comb begin
        if (cosel == CCW_CKO_SUB) begin
            co_tick = tick[CCW_SRC_SUB] && sub_on;
        end else if (cosel == CCW_CKO_F8) begin
            co_tick = per_run && pcnt_q[2:0] == 3'h7;
        end else if (cosel == CCW_CKO_F32) begin
            co_tick = per_run && pcnt_q == 5'h1f;
        end else begin
            co_tick = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            clock_output_pin <= 1'b0;
            clock_output_oe <= 1'b0;
        end else begin
            clock_output_oe <= !ext_bus_mode && cosel != CCW_CKO_PORT;
            if (co_tick) begin
                clock_output_pin <= !clock_output_pin;
            end
        end
    end

    // ----------------------------------------
    // bus pins
    // ----------------------------------------
    // hold pre-wait bus values in external bus mode
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bus_addr <= '0;
            bus_data <= '0;
            chip_select_n <= '1;
            byte_high_enable <= 1'b1;
        end else if (!(waiting && ext_bus_mode)) begin
            bus_addr <= bus_addr_in;
            bus_data <= bus_data_in;
            chip_select_n <= chip_select_n_in;
            byte_high_enable <= byte_high_enable_in;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            read_n <= 1'b1;
            write_n <= 1'b1;
            write_low_strobe_n <= 1'b1;
            write_high_strobe_n <= 1'b1;
            hold_acknowledge_n <= 1'b1;
            addr_latch <= 1'b0;
            bus_clock <= 1'b1;
        end else if (waiting && ext_bus_mode) begin
            read_n <= 1'b1;
            write_n <= 1'b1;
            write_low_strobe_n <= 1'b1;
            write_high_strobe_n <= 1'b1;
            hold_acknowledge_n <= 1'b1;
            addr_latch <= 1'b0;
            bus_clock <= 1'b1;
        end else begin
            read_n <= read_n_in;
            write_n <= write_n_in;
            write_low_strobe_n <= write_low_strobe_n_in;
            write_high_strobe_n <= write_high_strobe_n_in;
            hold_acknowledge_n <= hold_acknowledge_n_in;
            addr_latch <= addr_latch_in;
            if (cpu_pulse) begin
                bus_clock <= !bus_clock;
            end
        end
    end

    // ----------------------------------------
    // status outputs
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            main_osc_run <= 1'b0;
            sub_osc_run <= 1'b0;
            pll_enable <= 1'b0;
            in_wait <= 1'b0;
        end else begin
            main_osc_run <= main_on;
            sub_osc_run <= sub_on;
            pll_enable <= pll_on;
            in_wait <= waiting;
        end
    end
endmodule

// file: verif/ccw_top_properties.sv
/*
 * Checker for ccw_top wait mode: CPU, watchdog and peripheral gating, pins.
 * Assumes APB writes commit when psel, penable and pready are high together.
 */
module ccw_top_properties
    import ccw_pkg::*;
#(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 16,
    parameter int CS_W = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic wait_exec,
    input wire logic ext_bus_mode,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_data,
    input wire logic [CS_W-1:0] chip_select_n,
    input wire logic byte_high_enable,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic write_low_strobe_n,
    input wire logic write_high_strobe_n,
    input wire logic hold_acknowledge_n,
    input wire logic addr_latch,
    input wire logic bus_clock,
    input wire logic clock_output_pin,
    input wire logic cpu_clk_en,
    input wire logic watchdog_tick,
    input wire logic f1_tick,
    input wire logic f8_tick,
    input wire logic converter_clock_tick,
    input wire logic in_wait
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // shadow of written control bits
    // ----------------------------------------
    logic [7:0] cc0_q;
    logic wdt_src_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cc0_q <= CCW_CC0_RST;
            wdt_src_q <= 1'b0;
        end else if (psel && penable && pready && pwrite) begin
            if (paddr == CCW_ADDR_CC0) cc0_q <= pwdata[7:0];
            if (paddr == CCW_ADDR_PMT) wdt_src_q <= pwdata[CCW_PMT_WDT];
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // wait mode
    // ----------------------------------------
    a_wait_entry: assert property (wait_exec && !in_wait |-> ##[1:2] in_wait)
        else $error("wait instruction did not enter wait mode");
    a_cpu_gated: assert property (in_wait && $past(in_wait, 2) |-> !cpu_clk_en)
        else $error("cpu clock ran during wait");
    a_wdt_halted: assert property (in_wait && $past(in_wait, 6) && !wdt_src_q
        |-> !watchdog_tick)
        else $error("watchdog ran during wait");
    a_wdt_counts: assert property (in_wait && wdt_src_q
        |-> ##[0:16] (watchdog_tick || !in_wait))
        else $error("watchdog on internal oscillator stalled in wait");
    a_periph_gated: assert property (in_wait && $past(in_wait, 6)
        && cc0_q[CCW_CC0_GATE] |-> !f1_tick && !f8_tick && !converter_clock_tick)
        else $error("peripheral tick while gated in wait");
    a_bus_held: assert property (ext_bus_mode && in_wait && $past(in_wait, 2)
        |-> $stable(bus_addr) && $stable(bus_data) && $stable(chip_select_n)
        && $stable(byte_high_enable))
        else $error("bus pins moved during wait");
    a_strobes_parked: assert property (ext_bus_mode && in_wait && $past(in_wait, 2)
        |-> read_n && write_n && write_low_strobe_n && write_high_strobe_n
        && hold_acknowledge_n && bus_clock && !addr_latch)
        else $error("bus strobes not parked during wait");
    a_clkpin_frozen: assert property (!ext_bus_mode && in_wait && $past(in_wait, 6)
        && cc0_q[CCW_CC0_GATE] && cc0_q[CCW_CC0_CKO_LSB+1] |-> $stable(clock_output_pin))
        else $error("clock output moved while gated in wait");
endmodule

bind ccw_top ccw_top_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .CS_W(CS_W))
    u_ccw_top_properties (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .wait_exec, .ext_bus_mode, .bus_addr, .bus_data, .chip_select_n,
    .byte_high_enable, .read_n, .write_n, .write_low_strobe_n, .write_high_strobe_n,
    .hold_acknowledge_n, .addr_latch, .bus_clock, .clock_output_pin, .cpu_clk_en,
    .watchdog_tick, .f1_tick, .f8_tick, .converter_clock_tick, .in_wait);

// file: verif/ccw_top_tb_top.sv
/*
 * Self-checking bench for ccw_top: mode table, divider, wait mode over APB.
 * Assumes the checker is bound to ccw_top from its own file.
 */
module ccw_top_tb_top
    import ccw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_bus_mode = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [1:0] ctl = 2'h0;
    logic [15:0] cnt = 16'h0;
    logic pready, pslverr, rerr, cpu_clk_en, f1_tick, main_osc_run, in_wait;
    int miscompares = 0;
    int checks = 0;
    int dv[4] = '{1, 2, 4, 16};

    always #20 ref_clk = ~ref_clk;
    // oscillators and bus inputs all keep moving, so holds are real
    always @(posedge ref_clk) cnt <= cnt + 16'h1;

    ccw_top u_ccw_top (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .main_osc_pin(cnt[1]), .sub_osc_pin(cnt[3]), .ioc_osc_pin(cnt[2]),
        .pll_osc_pin(cnt[0]), .wait_exec(ctl[0]), .wait_wake(ctl[1]), .ext_bus_mode,
        .bus_addr_in({cnt[3:0], cnt}), .bus_data_in(cnt), .chip_select_n_in(cnt[3:0]),
        .byte_high_enable_in(cnt[0]), .read_n_in(cnt[1]), .write_n_in(cnt[2]),
        .write_low_strobe_n_in(cnt[3]), .write_high_strobe_n_in(cnt[4]),
        .hold_acknowledge_n_in(cnt[5]), .addr_latch_in(cnt[6]), .bus_addr(), .bus_data(),
        .chip_select_n(), .byte_high_enable(), .read_n(), .write_n(), .write_low_strobe_n(),
        .write_high_strobe_n(), .hold_acknowledge_n(), .addr_latch(), .bus_clock(),
        .clock_output_pin(), .clock_output_oe(), .cpu_clk_en, .watchdog_tick(), .f1_tick,
        .f2_tick(), .f8_tick(), .f32_tick(), .converter_clock_tick(),
        .sub_clock_div32_tick(), .main_osc_run, .sub_osc_run(), .pll_enable(), .in_wait);

    // ----------------------------------------
    // bus cycles and comparisons
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_cnt(input int g, input int e);
        checks++;
        if (g < e - 1 || g > e + 1) begin
            miscompares++;
            $display("wrong value at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdata, e);
    endtask
    // pulses of cpu enable and f1 over 256 cycles; edge jitter allows one off
    task automatic meas(input int ec, input int ef);
        int nc;
        int nf;
        nc = 0;
        nf = 0;
        repeat (16) @(posedge ref_clk);
        repeat (256) begin
            @(posedge ref_clk);
            if (cpu_clk_en === 1'b1) nc++;
            if (f1_tick === 1'b1) nf++;
        end
        chk_cnt(nc, ec);
        chk_cnt(nf, ef);
    endtask
    task automatic sweep(input int base, input int ef, input logic [31:0] st0,
        input logic [31:0] st);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, CCW_ADDR_CC1, 32'(i) << 6);
            rd(CCW_ADDR_STAT, (i == 0) ? st0 : st);
            meas(base / dv[i], ef);
        end
    endtask
    task automatic pulse(input logic [1:0] v);
        @(posedge ref_clk);
        ctl <= v;
        @(posedge ref_clk);
        ctl <= 2'h0;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic rst();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(CCW_ADDR_CC0, 32'h40);
        rd(CCW_ADDR_STAT, 32'h2);
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rdata, 32'h0);
        meas(8, 64);
        apb(1'b1, CCW_ADDR_CC0, 32'h0);
        sweep(64, 64, 32'h1, 32'h2);
        apb(1'b1, CCW_ADDR_CC0, 32'h90);
        rd(CCW_ADDR_STAT, 32'h3);
        apb(1'b1, CCW_ADDR_CC0, 32'hb0);
        rd(CCW_ADDR_CC0, 32'hf0);
        rd(CCW_ADDR_STAT, 32'h4);
        chk({31'h0, main_osc_run}, 32'h0);
        meas(16, 0);
        rst();
        apb(1'b1, CCW_ADDR_OSD, 32'h2);
        apb(1'b1, CCW_ADDR_CC0, 32'h0);
        sweep(32, 32, 32'h5, 32'h5);
        apb(1'b1, CCW_ADDR_CC0, 32'h40);
        meas(4, 32);
        apb(1'b1, CCW_ADDR_CC1, 32'h80);
        apb(1'b1, CCW_ADDR_CC0, 32'h20);
        rd(CCW_ADDR_CC0, 32'h20);
        rd(CCW_ADDR_STAT, 32'h6);
        meas(8, 32);
        rst();
        ext_bus_mode <= 1'b1;
        apb(1'b1, CCW_ADDR_CC0, 32'h14);
        chk({31'h0, in_wait}, 32'h0);
        pulse(2'h1);
        rd(CCW_ADDR_STAT, 32'h9);
        meas(0, 0);
        repeat (600) @(posedge ref_clk);
        pulse(2'h2);
        ext_bus_mode <= 1'b0;
        apb(1'b1, CCW_ADDR_PMT, 32'h4);
        apb(1'b1, CCW_ADDR_CC0, 32'h16);
        pulse(2'h1);
        meas(0, 0);
        pulse(2'h2);
        apb(1'b1, CCW_ADDR_CC0, 32'h10);
        pulse(2'h1);
        meas(0, 64);
        pulse(2'h2);
        meas(64, 64);
        print_verdict();
    end

    initial begin
        repeat (30000) @(posedge ref_clk);
        miscompares++;
        print_verdict();
    end
endmodule
